/* File: verilog/isw_pkg.sv */
/*
  Constants shared by the sub-word access and register move decoder:
  register map, field positions, reset values and encodings.
  Assumes a single 40 MHz core clock and a word-addressed register port.
*/
// Summary of operation
// - condition all ones means unconditional access
// - sub-word transfer is 48-bit, no compute
// - sub-word options need byte-space index
// - non byte-space index raises illegal interrupt
// - byte load zero-extends, store writes low byte
// - short load zero-extends, store writes low half
// - signed options load only, sign-extend
// - short load: lower address is low byte
// - result in bits 39..8, low byte cleared
// - index update adds modifier times access size
// - second element offset k: 1, 2, 4, broadcast 0
// - broadcast on index 1/9: no second offset
// - SISD: condition on first element only
// - SIMD: each element uses own condition
// - SIMD move also moves complementary registers
// - move compute runs in parallel, both elements
// - SIMD non-complementary move needs both conditions
// - g selects memory, d direction, u modify order
// - size bit byte/short, load adds extension bit
// - zero compute field means none, ones unconditional
// - post-modify addresses unmodified, then writes back
package isw_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_INDEX_BASE = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h11;
  localparam logic [7:0] REG_BYTE_BASE = 8'h12;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SIMD_BIT = 0;
  localparam int CTRL_BCAST1_BIT = 1;
  localparam int CTRL_BCAST9_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int STAT_EXEC_X_BIT = 2;
  localparam int STAT_EXEC_Y_BIT = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] BYTE_BASE_RESET = 32'h8000_0000;
  localparam logic [31:0] INDEX_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [4:0] COND_ALWAYS = 5'h1f;
  localparam logic [38:0] COMPUTE_NONE = 39'h00_0000_0000;
  localparam logic [3:0] INDEX_BCAST1 = 4'h1;
  localparam logic [3:0] INDEX_BCAST9 = 4'h9;
  localparam logic [2:0] K_NORMAL = 3'h1;
  localparam logic [2:0] K_SHORT = 3'h2;
  localparam logic [2:0] K_BYTE = 3'h4;
  localparam logic [2:0] K_BCAST = 3'h0;

  typedef enum logic [1:0] {
    ISW_IDLE = 2'b00,
    ISW_ISSUE = 2'b01,
    ISW_CAPT = 2'b11,
    ISW_WB = 2'b10
  } isw_state_t;

endpackage

/* File: verilog/isw_decoder.sv */
/*
  Decoder and executor for the conditional index-relative sub-word
  memory transfer and the conditional universal-register move.
  Assumes memory answers a byte read while its strobe stands,
  and that condition results arrive already evaluated per element.
*/
// The plain strobed port and the placing of the registers are this design's own decisions.
module isw_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // instruction issue
  input wire logic instr_valid,
  input wire logic instr_is_move,
  input wire logic [4:0] instr_cond,
  input wire logic instr_g,
  input wire logic instr_d,
  input wire logic instr_u,
  input wire logic instr_size,
  input wire logic instr_sext,
  input wire logic [5:0] instr_imm6,
  input wire logic [2:0] instr_ireg,
  input wire logic [3:0] instr_dreg,
  input wire logic [38:0] instr_compute,
  input wire logic [6:0] move_dst,
  input wire logic [6:0] move_src,
  input wire logic move_dst_compl,
  output logic instr_ready,
  // condition results per element
  input wire logic cond_true_x,
  input wire logic cond_true_y,
  // store data from register file
  input wire logic [31:0] store_data_x,
  input wire logic [31:0] store_data_y,
  // memory port
  output logic mem_sel,
  output logic [31:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // register file writeback
  output logic rf_wr_x,
  output logic rf_wr_y,
  output logic [3:0] rf_waddr,
  output logic [39:0] rf_wdata_x,
  output logic [39:0] rf_wdata_y,
  // register move and compute strobes, illegal space interrupt
  output logic move_x,
  output logic move_y,
  output logic [6:0] move_dst_out,
  output logic [6:0] move_src_out,
  output logic compute_x,
  output logic compute_y,
  output logic illegal_space_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  isw_pkg::isw_state_t st_q;
  logic [31:0] index_q [16];
  logic [2:0] ctrl_q;
  logic [31:0] byte_base_q;
  logic illegal_flag_q;
  logic exec_x_q, exec_y_q;
  logic simd_q, short_q, sext_q, store_q;
  logic el_q, byte_q;
  logic [31:0] addr_x_q, addr_y_q;
  logic [15:0] asm_x_q, asm_y_q;
  logic [31:0] st_x_q, st_y_q;
  logic take, take_acc, take_mov;
  logic uncond, ex_x, ex_y, any_ex;
  logic [3:0] idx;
  logic [31:0] ival, scaled, modified;
  logic bcast;
  logic [2:0] k;
  logic in_byte_space;
  logic last_step;
  logic [31:0] step_addr;
  logic [7:0] step_wdata;

  assign take = instr_valid && instr_ready;
  assign take_acc = take && !instr_is_move;
  assign take_mov = take && instr_is_move;
  assign uncond = instr_cond == isw_pkg::COND_ALWAYS;
  // sisd looks at the first element only
  assign ex_x = uncond || cond_true_x;
  assign ex_y = ctrl_q[isw_pkg::CTRL_SIMD_BIT] && (uncond || cond_true_y);
  assign any_ex = ex_x || ex_y;
  assign idx = {instr_g, instr_ireg};
  assign ival = index_q[idx];
  // modifier scaled by access size in bytes
  assign scaled = instr_size ? {{25{instr_imm6[5]}}, instr_imm6, 1'b0}
                             : {{26{instr_imm6[5]}}, instr_imm6};
  assign modified = ival + scaled;
  assign bcast = !instr_d && ((idx == isw_pkg::INDEX_BCAST1 && ctrl_q[isw_pkg::CTRL_BCAST1_BIT])
                 || (idx == isw_pkg::INDEX_BCAST9 && ctrl_q[isw_pkg::CTRL_BCAST9_BIT]));
  assign k = bcast ? isw_pkg::K_BCAST : (instr_size ? isw_pkg::K_SHORT : isw_pkg::K_BYTE);
  assign in_byte_space = ival >= byte_base_q;
  assign last_step = (byte_q == short_q) && (el_q || !exec_y_q);
  assign step_addr = (el_q ? addr_y_q : addr_x_q) + {31'h0, byte_q};
  assign step_wdata = el_q ? (byte_q ? st_y_q[15:8] : st_y_q[7:0])
                           : (byte_q ? st_x_q[15:8] : st_x_q[7:0]);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= isw_pkg::ISW_IDLE;
    end else begin
      case (st_q)
        isw_pkg::ISW_IDLE: begin
          // the check stops the access before any memory strobe
          if (take_acc && any_ex && in_byte_space) begin
            st_q <= isw_pkg::ISW_ISSUE;
          end
        end
        isw_pkg::ISW_ISSUE: st_q <= isw_pkg::ISW_CAPT;
        isw_pkg::ISW_CAPT: st_q <= last_step ? isw_pkg::ISW_WB : isw_pkg::ISW_ISSUE;
        isw_pkg::ISW_WB: st_q <= isw_pkg::ISW_IDLE;
        default: st_q <= isw_pkg::ISW_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      exec_x_q <= 1'b0;
      exec_y_q <= 1'b0;
      simd_q <= 1'b0;
      short_q <= 1'b0;
      sext_q <= 1'b0;
      store_q <= 1'b0;
      addr_x_q <= 32'h0;
      addr_y_q <= 32'h0;
      st_x_q <= 32'h0;
      st_y_q <= 32'h0;
      rf_waddr <= 4'h0;
      mem_sel <= 1'b0;
    end else if (st_q == isw_pkg::ISW_IDLE && take_acc) begin
      exec_x_q <= ex_x;
      exec_y_q <= ex_y;
      simd_q <= ctrl_q[isw_pkg::CTRL_SIMD_BIT];
      short_q <= instr_size;
      sext_q <= instr_sext && !instr_d;
      store_q <= instr_d;
      // post-modify uses the unmodified index
      addr_x_q <= instr_u ? ival : modified;
      addr_y_q <= (instr_u ? ival : modified) + {29'h0, k};
      st_x_q <= store_data_x;
      st_y_q <= store_data_y;
      rf_waddr <= instr_dreg;
      mem_sel <= instr_g;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      el_q <= 1'b0;
      byte_q <= 1'b0;
    end else if (st_q == isw_pkg::ISW_IDLE) begin
      el_q <= !ex_x;
      byte_q <= 1'b0;
    end else if (st_q == isw_pkg::ISW_CAPT && !last_step) begin
      if (byte_q == short_q) begin
        el_q <= 1'b1;
        byte_q <= 1'b0;
      end else begin
        byte_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 8'h0;
    end else begin
      // strobes are set in the issue state and stand for one cycle, during the capture state
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (st_q == isw_pkg::ISW_ISSUE) begin
        mem_rd <= !store_q;
        mem_wr <= store_q;
        mem_addr <= step_addr;
        mem_wdata <= step_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      asm_x_q <= 16'h0;
      asm_y_q <= 16'h0;
    end else if (st_q == isw_pkg::ISW_IDLE) begin
      asm_x_q <= 16'h0;
      asm_y_q <= 16'h0;
    end else if (st_q == isw_pkg::ISW_CAPT && !store_q) begin
      // lower address lands in the low byte
      if (!el_q && !byte_q) asm_x_q[7:0] <= mem_rdata;
      if (!el_q && byte_q) asm_x_q[15:8] <= mem_rdata;
      if (el_q && !byte_q) asm_y_q[7:0] <= mem_rdata;
      if (el_q && byte_q) asm_y_q[15:8] <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // register file writeback
  // ----------------------------------------------------------------
  function automatic logic [39:0] isw_extend(input logic [15:0] v, input logic sh,
                                             input logic se);
    logic [31:0] w;
    w = 32'h0;
    if (sh) begin
      w = se ? {{16{v[15]}}, v} : {16'h0, v};
    end else begin
      w = se ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]};
    end
    return {w, 8'h00};
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rf_wr_x <= 1'b0;
      rf_wr_y <= 1'b0;
      rf_wdata_x <= 40'h0;
      rf_wdata_y <= 40'h0;
    end else begin
      rf_wr_x <= 1'b0;
      rf_wr_y <= 1'b0;
      if (st_q == isw_pkg::ISW_WB && !store_q) begin
        rf_wr_x <= exec_x_q;
        rf_wr_y <= exec_y_q;
        rf_wdata_x <= isw_extend(asm_x_q, short_q, sext_q);
        rf_wdata_y <= isw_extend(asm_y_q, short_q, sext_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // register move with optional compute
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      move_x <= 1'b0;
      move_y <= 1'b0;
      compute_x <= 1'b0;
      compute_y <= 1'b0;
      move_dst_out <= 7'h0;
      move_src_out <= 7'h0;
    end else begin
      move_x <= 1'b0;
      move_y <= 1'b0;
      compute_x <= 1'b0;
      compute_y <= 1'b0;
      if (take_mov) begin
        move_dst_out <= move_dst;
        move_src_out <= move_src;
        if (ctrl_q[isw_pkg::CTRL_SIMD_BIT] && !move_dst_compl) begin
          // a shared destination must not be half written
          move_x <= ex_x && ex_y;
        end else begin
          move_x <= ex_x;
          move_y <= ex_y;
        end
        compute_x <= ex_x && instr_compute != isw_pkg::COMPUTE_NONE;
        compute_y <= ex_y && instr_compute != isw_pkg::COMPUTE_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // index registers and illegal event
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) index_q[i] <= isw_pkg::INDEX_RESET;
    end else if (take_acc && any_ex && in_byte_space && instr_u) begin
      index_q[idx] <= modified;
    end else if (reg_wr && reg_addr[7:4] == isw_pkg::REG_INDEX_BASE[7:4]) begin
      index_q[reg_addr[3:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      illegal_space_irq <= 1'b0;
    end else begin
      illegal_space_irq <= take_acc && any_ex && !in_byte_space;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q <= isw_pkg::CTRL_RESET;
      byte_base_q <= isw_pkg::BYTE_BASE_RESET;
    end else if (reg_wr && reg_addr == isw_pkg::REG_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == isw_pkg::REG_BYTE_BASE) begin
      byte_base_q <= reg_wdata;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      illegal_flag_q <= 1'b0;
    end else if (illegal_space_irq) begin
      illegal_flag_q <= 1'b1;
    end else if (reg_wr && reg_addr == isw_pkg::REG_STATUS
                 && reg_wdata[isw_pkg::STAT_ILLEGAL_BIT]) begin
      illegal_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr[7:4] == isw_pkg::REG_INDEX_BASE[7:4]) begin
        reg_rdata <= index_q[reg_addr[3:0]];
      end else if (reg_addr == isw_pkg::REG_CTRL) begin
        reg_rdata <= {29'h0, ctrl_q};
      end else if (reg_addr == isw_pkg::REG_STATUS) begin
        reg_rdata <= {28'h0, exec_y_q, exec_x_q, illegal_flag_q, st_q != isw_pkg::ISW_IDLE};
      end else if (reg_addr == isw_pkg::REG_BYTE_BASE) begin
        reg_rdata <= byte_base_q;
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      instr_ready <= 1'b0;
    end else begin
      // ready drops the cycle after an executed access with a byte-space index is taken
      instr_ready <= (st_q == isw_pkg::ISW_IDLE && !(take_acc && any_ex && in_byte_space))
                     || st_q == isw_pkg::ISW_WB;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_illegal_no_access: assert property (
    illegal_space_irq |-> st_q == isw_pkg::ISW_IDLE ##1 (!mem_rd && !mem_wr))
    else $error("memory touched after illegal address space");
  a_low_byte_zero: assert property (
    (rf_wr_x || rf_wr_y) |-> rf_wdata_x[7:0] == 8'h00 && rf_wdata_y[7:0] == 8'h00)
    else $error("result low byte not cleared");
  a_byte_zero_ext: assert property (
    rf_wr_x && !short_q && !sext_q |-> rf_wdata_x[39:16] == 24'h0)
    else $error("byte load not zero extended");
  a_short_sign_ext: assert property (
    rf_wr_x && short_q && sext_q |-> rf_wdata_x[39:24] == {16{rf_wdata_x[23]}})
    else $error("short load not sign extended");
  a_sisd_first_only: assert property (
    (rf_wr_y || move_y) |-> simd_q || ctrl_q[isw_pkg::CTRL_SIMD_BIT])
    else $error("second element active outside simd");
  a_short_next_byte: assert property (
    mem_rd && byte_q == 1'b0 && st_q == isw_pkg::ISW_CAPT && short_q
    |-> ##2 mem_rd && mem_addr == $past(mem_addr, 2) + 32'h1)
    else $error("short halves not at consecutive addresses");
  a_move_both_true: assert property (
    move_x && $past(ctrl_q[isw_pkg::CTRL_SIMD_BIT]) && !$past(move_dst_compl)
    && $past(instr_cond) != isw_pkg::COND_ALWAYS |-> $past(cond_true_x) && $past(cond_true_y))
    else $error("shared move done without both conditions");
  a_compute_field: assert property (
    compute_x |-> $past(instr_compute) != isw_pkg::COMPUTE_NONE)
    else $error("compute issued for empty field");
  a_store_no_rf: assert property (
    mem_wr |-> ##1 (!rf_wr_x && !rf_wr_y) [*5])
    else $error("store wrote the register file");

endmodule

/* File: sim/isw_mem_model.sv */
/*
  Byte-wide model of the core's data and program memory.
  Assumes registered one-cycle strobes; read data answer while the strobe stands.
*/
module isw_mem_model (
  // clock
  input wire logic sys_clk,
  // memory port
  input wire logic mem_sel,
  input wire logic [31:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [32:0]];
  logic [7:0] rd_v;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  initial mem_rdata = 8'h00;
  always @(posedge sys_clk) begin
    if (mem_wr === 1'b1) begin
      mem[{mem_sel, mem_addr}] = mem_wdata;
    end
  end

  // untouched bytes read back as an address pattern
  // inverse outside the strobe, so an early or late capture shows
  always @(mem_rd, mem_sel, mem_addr) begin
    rd_v = mem.exists({mem_sel, mem_addr}) ? mem[{mem_sel, mem_addr}] :
        (mem_addr[7:0] ^ {mem_sel, 7'h35});
    mem_rdata = (mem_rd === 1'b1) ? rd_v : ~rd_v;
  end
endmodule

/* File: sim/test_indexed_subword_access_and_reg_move.sv */
/*
  Self-checking bench for the sub-word access and register move decoder.
  Assumes the decoder package and the byte memory model on the memory port.
*/
module test_indexed_subword_access_and_reg_move;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] kind;
    logic [63:0] mask;
    logic [63:0] val;
  } isw_ev_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
  logic instr_valid = 1'b0, instr_is_move = 1'b0, instr_g = 1'b0, instr_d = 1'b0;
  logic instr_u = 1'b0, instr_size = 1'b0, instr_sext = 1'b0, move_dst_compl = 1'b0;
  logic [4:0] instr_cond = 5'h1f;
  logic [5:0] instr_imm6 = 6'h00;
  logic [2:0] instr_ireg = 3'h0;
  logic [3:0] instr_dreg = 4'h0;
  logic [38:0] instr_compute = 39'h0;
  logic [6:0] move_dst = 7'h00, move_src = 7'h00;
  logic cond_true_x = 1'b0, cond_true_y = 1'b0;
  logic [31:0] store_data_x = 32'h0, store_data_y = 32'h0;
  logic instr_ready, mem_sel, mem_rd, mem_wr, rf_wr_x, rf_wr_y, move_x, move_y;
  logic compute_x, compute_y, illegal_space_irq;
  logic [31:0] reg_rdata, mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [3:0] rf_waddr;
  logic [39:0] rf_wdata_x, rf_wdata_y;
  logic [6:0] move_dst_out, move_src_out;
  logic [31:0] idx [16];
  logic [2:0] ctrl_m = 3'h0;
  isw_ev_t exp_q [$];
  logic [7:0] sh [logic [32:0]];
  int num_errors = 0;
  int samples_checked = 0;

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rd_q <= reg_rd;

  isw_decoder DUT (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .instr_valid, .instr_is_move, .instr_cond, .instr_g, .instr_d, .instr_u, .instr_size,
    .instr_sext, .instr_imm6, .instr_ireg, .instr_dreg, .instr_compute, .move_dst, .move_src,
    .move_dst_compl, .instr_ready, .cond_true_x, .cond_true_y, .store_data_x, .store_data_y,
    .mem_sel, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .rf_wr_x, .rf_wr_y,
    .rf_waddr, .rf_wdata_x, .rf_wdata_y, .move_x, .move_y, .move_dst_out, .move_src_out,
    .compute_x, .compute_y, .illegal_space_irq
  );
  isw_mem_model mem_model (
    .sys_clk, .mem_sel, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata
  );

  // ----------------------------------------------------------------
  // expected values and the output watcher
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input logic s, input logic [31:0] a);
    return sh.exists({s, a}) ? sh[{s, a}] : a[7:0] ^ {s, 7'h35};
  endfunction

  function automatic logic [39:0] ld(input logic s, sz, se, input logic [31:0] a);
    logic [31:0] v;
    v = sz ? {16'h0, pat(s, a + 32'h1), pat(s, a)} : {24'h0, pat(s, a)};
    if (se) v = sz ? {{16{v[15]}}, v[15:0]} : {{24{v[7]}}, v[7:0]};
    return {v, 8'h00};
  endfunction

  task automatic ev(input logic [3:0] k, input logic [63:0] v, input logic [63:0] m);
    isw_ev_t e;
    e.kind = k;
    e.mask = m;
    e.val = v & m;
    exp_q.push_back(e);
  endtask

  task automatic chk(input logic [3:0] k, input logic [63:0] v);
    isw_ev_t e;
    samples_checked++;
    e = '0;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    if (e.kind !== k || (v & e.mask) !== e.val) begin
      num_errors++;
      $display("FAIL event %0d expected %0d:%h seen %h", k, e.kind, e.val, v);
    end
  endtask

  // anything not noted in the queue is a mismatch
  always @(negedge sys_clk) begin
    if (reset_n === 1'b1) begin
      if (rd_q === 1'b1) chk(4'h7, {32'h0, reg_rdata});
      if (mem_rd === 1'b1) chk(4'h4, {31'h0, mem_sel, mem_addr});
      if (mem_wr === 1'b1) chk(4'h3, {23'h0, mem_sel, mem_addr, mem_wdata});
      if (rf_wr_x === 1'b1) chk(4'h1, {20'h0, rf_waddr, rf_wdata_x});
      if (rf_wr_y === 1'b1) chk(4'h2, {20'h0, rf_waddr, rf_wdata_y});
      if ((move_x | move_y | compute_x | compute_y) !== 1'b0)
        chk(4'h5, {46'h0, move_x, move_y, compute_x, compute_y, move_dst_out, move_src_out});
      if (illegal_space_irq === 1'b1) chk(4'h6, 64'h1);
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    ev(4'h7, {32'h0, d}, {32'h0, m});
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic setctrl(input logic [2:0] c);
    wr(8'h10, {29'h0, c});
    ctrl_m = c;
  endtask

  task automatic seti(input logic [3:0] i, input logic [31:0] v);
    wr({4'h0, i}, v);
    idx[i] = v;
  endtask

  task automatic offer();
    int n;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    n = 0;
    while (instr_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 40) begin
      num_errors++;
      $display("FAIL instr_ready expected 1 seen %b", instr_ready);
    end
  endtask

  task automatic acc(input logic g, d, u, sz, se, input logic [5:0] imm,
      input logic [2:0] ir, input logic [4:0] cnd, input logic cx, cy);
    logic [3:0] ix, dr;
    logic [31:0] b, a, ad, mv, sx, sy;
    logic xe, ye, bc;
    logic [2:0] k;
    ix = {g, ir};
    b = idx[ix];
    dr = 4'($urandom);
    sx = $urandom;
    sy = $urandom;
    xe = cnd == 5'h1f || cx;
    ye = ctrl_m[0] && (cnd == 5'h1f || cy);
    mv = {{26{imm[5]}}, imm} << sz;
    a = u ? b : b + mv;
    bc = !d && ((ctrl_m[1] && ix == 4'h1) || (ctrl_m[2] && ix == 4'h9));
    k = bc ? 3'h0 : (sz ? 3'h2 : 3'h4);
    if (xe || ye) begin
      if (b < isw_pkg::BYTE_BASE_RESET) ev(4'h6, 64'h1, '1);
      else begin
        for (int e = 0; e < 2; e++)
          for (int i = 0; i <= int'(sz); i++)
            if (e ? ye : xe) begin
              ad = a + (e ? 32'(k) : 32'h0) + 32'(i);
              if (d) begin
                sh[{g, ad}] = 8'((e ? sy : sx) >> (8 * i));
                ev(4'h3, {23'h0, g, ad, sh[{g, ad}]}, '1);
              end else ev(4'h4, {31'h0, g, ad}, '1);
            end
        if (!d && xe) ev(4'h1, {20'h0, dr, ld(g, sz, se, a)}, '1);
        if (!d && ye) ev(4'h2, {20'h0, dr, ld(g, sz, se, a + 32'(k))}, '1);
        if (u) idx[ix] = b + mv;
      end
    end
    @(posedge sys_clk);
    instr_is_move <= 1'b0;
    instr_g <= g;
    instr_d <= d;
    instr_u <= u;
    instr_size <= sz;
    instr_sext <= se;
    instr_imm6 <= imm;
    instr_ireg <= ir;
    instr_dreg <= dr;
    instr_cond <= cnd;
    cond_true_x <= cx;
    cond_true_y <= cy;
    store_data_x <= sx;
    store_data_y <= sy;
    instr_compute <= {7'h1, 32'($urandom)};
    offer();
    rd({4'h0, ix}, idx[ix], '1);
  endtask

  task automatic mov(input logic [4:0] cnd, input logic cx, cy, cpl, input logic [38:0] cmp);
    logic xe, ye, mx, my, px, py;
    logic [6:0] ds, sr;
    ds = 7'($urandom);
    sr = 7'($urandom);
    xe = cnd == 5'h1f || cx;
    ye = ctrl_m[0] && (cnd == 5'h1f || cy);
    mx = xe && (cpl || !ctrl_m[0] || ye);
    my = ye && cpl;
    px = xe && cmp != 39'h0;
    py = ye && cmp != 39'h0;
    if (mx || my || px || py)
      ev(4'h5, {46'h0, mx, my, px, py, ds, sr}, {46'h0, 4'hf, {14{mx || my}}});
    @(posedge sys_clk);
    instr_is_move <= 1'b1;
    instr_cond <= cnd;
    cond_true_x <= cx;
    cond_true_y <= cy;
    move_dst_compl <= cpl;
    instr_compute <= cmp;
    move_dst <= ds;
    move_src <= sr;
    offer();
  endtask

  task automatic test_done();
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("FAIL queue expected 0 seen %0d", exp_q.size());
    end
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(14775));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h10, 32'h0, '1);
    rd(8'h12, isw_pkg::BYTE_BASE_RESET, '1);
    rd(8'h05, isw_pkg::INDEX_RESET, '1);
    rd(8'h20, 32'h0, '1);
    seti(4'h1, 32'h8000_0010);
    seti(4'h9, 32'h8000_0101);
    seti(4'h3, 32'h8000_1000 | (32'($urandom) & 32'hfff));
    seti(4'h2, 32'h0000_0040);
    setctrl(3'h0);
    acc(0, 0, 0, 0, 0, 6'($urandom), 3'h1, 5'h03, 1, 0);
    acc(1, 0, 1, 1, 1, 6'h02, 3'h1, 5'h1f, 0, 0);
    acc(0, 0, 1, 0, 0, 6'h01, 3'h1, 5'h04, 0, 1);
    acc(0, 1, 1, 0, 0, 6'($urandom), 3'h3, 5'h1f, 1, 1);
    setctrl(3'h1);
    for (int m = 0; m < 8; m++)
      acc(0, m[2], 1, m[1], m[0], 6'($urandom), 3'h3, 5'h06, 1, 1);
    acc(0, 0, 1, 0, 1, 6'($urandom), 3'h3, 5'h06, 0, 1);
    acc(0, 1, 1, 1, 0, 6'($urandom), 3'h3, 5'h06, 1, 0);
    setctrl(3'h3);
    acc(0, 0, 1, 0, 0, 6'h01, 3'h1, 5'h1f, 1, 1);
    setctrl(3'h5);
    acc(1, 0, 1, 1, 0, 6'h3f, 3'h1, 5'h1f, 1, 1);
    acc(1, 1, 1, 1, 0, 6'h01, 3'h1, 5'h1f, 1, 1);
    acc(0, 0, 1, 0, 0, 6'h01, 3'h2, 5'h1f, 1, 1);
    rd(8'h11, 32'h2, 32'h3);
    wr(8'h11, 32'h2);
    rd(8'h11, 32'h0, 32'h2);
    for (int s = 0; s < 2; s++) begin
      setctrl({2'h0, 1'(s)});
      repeat (16)
        mov($urandom_range(0, 1) ? 5'h1f : 5'($urandom_range(0, 30)), 1'($urandom),
            1'($urandom), 1'($urandom),
            $urandom_range(0, 1) ? {7'h0, 32'($urandom)} : 39'h0);
    end
    repeat (4) @(posedge sys_clk);
    test_done();
  end

  initial begin
    #(25ns * 6000);
    num_errors++;
    $display("FAIL watchdog expected finish seen timeout");
    test_done();
  end
endmodule
